// ---- rtl/bccd_decoder.v ----
// bus cycle command decoder: status decode, command strobes, transceiver controls
// How it works
// - direction high on writes, low on reads
// - data enable off whenever direction changes
// - direction high while no cycle runs, one clock after data enable goes off
// - direction follows cycle type, held while data enable is on
// - strobes low, delay and ready timed
// - 000 gives interrupt ack with cascade
// - 001 gives io read, direction low
// - 010 gives io write, direction high
// - status lines both high means idle
// - 100 is halt, no outputs
// - 101 gives memory read, direction low
// - 110 gives memory write, direction high
// - status sampled while idle or in the last command clock starts cycle
// - ready high repeats command state
// - hold off high withholds the command
// - timing select delays command, and enable on writes only
`include "bccd_map.vh"

module bccd_decoder (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// status from the local bus master
	input wire mem_io_select,
	input wire status_hi_n,
	input wire status_lo_n,
	// cycle control inputs
	input wire ready_n,
	input wire command_hold_off,
	input wire bus_timing_select,
	// command strobes
	output reg int_ack_cmd_n,
	output reg io_read_cmd_n,
	output reg io_write_cmd_n,
	output reg mem_read_cmd_n,
	output reg mem_write_cmd_n,
	// transceiver and latch controls
	output reg data_direction,
	output reg data_enable,
	output reg addr_latch_strobe,
	output reg cascade_strobe
);

reg [3:0] state_q;
reg [3:0] state_d;
reg [`BCCD_NCMD-1:0] sel_q;
reg [`BCCD_NCMD-1:0] sel_d;
reg wr_q;
reg wr_d;
reg go_q;
reg go_d;
wire [`BCCD_NCMD-1:0] cmd_n_d;
reg dir_d;
reg den_d;
reg ale_d;
reg mce_d;
wire [2:0] code;
wire st_idle;
wire st_stat;
wire st_cmd1;
wire st_cmd2;
wire end_cyc;
wire may_start;
wire start;
reg [`BCCD_NCMD-1:0] dec;
wire dec_wr;
wire nxt_cyc;
wire nxt_cmd;
wire allow;
wire dir_want;

assign code = {mem_io_select, status_hi_n, status_lo_n};
assign st_idle = state_q[`BCCD_B_IDLE];
assign st_stat = state_q[`BCCD_B_STAT];
assign st_cmd1 = state_q[`BCCD_B_CMD1];
assign st_cmd2 = state_q[`BCCD_B_CMD2];

// end of the second command state with ready low closes the cycle
assign end_cyc = st_cmd2 & ~ready_n;
assign may_start = st_idle | end_cyc;

// either status line low starts a cycle; halt and idle codes do not
always @*
begin
	dec = {`BCCD_NCMD{1'b0}};
	case (code)
		`BCCD_CODE_INT_ACK_CMD: dec[`BCCD_CMD_INT_ACK_CMD] = 1'b1;
		`BCCD_CODE_IORD: dec[`BCCD_CMD_IORD] = 1'b1;
		`BCCD_CODE_IOWR: dec[`BCCD_CMD_IOWR] = 1'b1;
		`BCCD_CODE_MRD: dec[`BCCD_CMD_MRD] = 1'b1;
		`BCCD_CODE_MWR: dec[`BCCD_CMD_MWR] = 1'b1;
		default: dec = {`BCCD_NCMD{1'b0}};
	endcase
end
assign dec_wr = dec[`BCCD_CMD_IOWR] | dec[`BCCD_CMD_MWR];
assign start = may_start & (~status_hi_n | ~status_lo_n) & (code != `BCCD_CODE_HALT);

// bus state sequencing
always @*
begin
	state_d = `BCCD_ST_IDLE;
	case (state_q)
		`BCCD_ST_IDLE:
		begin
			if (start)
				state_d = `BCCD_ST_STAT;
		end
		`BCCD_ST_STAT:
		begin
			state_d = `BCCD_ST_CMD1;
		end
		`BCCD_ST_CMD1:
		begin
			state_d = `BCCD_ST_CMD2;
		end
		`BCCD_ST_CMD2:
		begin
			if (ready_n)
				state_d = `BCCD_ST_CMD1;
			else if (start)
				state_d = `BCCD_ST_STAT;
			else
				state_d = `BCCD_ST_IDLE;
		end
		default:
		begin
			state_d = `BCCD_ST_IDLE;
		end
	endcase
end

assign nxt_cyc = ~state_d[`BCCD_B_IDLE];
assign nxt_cmd = state_d[`BCCD_B_CMD1] | state_d[`BCCD_B_CMD2];

// cycle type capture
always @*
begin
	sel_d = sel_q;
	wr_d = wr_q;
	if (start)
	begin
		sel_d = dec;
		wr_d = dec_wr;
	end
	else if (~nxt_cyc)
	begin
		sel_d = {`BCCD_NCMD{1'b0}};
		wr_d = 1'b0;
	end
end

// command enable: timing select adds one clock, hold off keeps it back
assign allow = bus_timing_select ? (st_cmd1 | st_cmd2) : (st_stat | st_cmd1 | st_cmd2);

always @*
begin
	go_d = 1'b0;
	if (nxt_cmd & ~start)
		go_d = go_q | (allow & ~command_hold_off);
end

// one strobe per cycle type, low only while enabled in command states
genvar gi;
generate
	for (gi = 0; gi < `BCCD_NCMD; gi = gi + 1)
	begin : g_cmd
		assign cmd_n_d[gi] = ~(go_d & sel_d[gi]);
	end
endgenerate

// direction from the cycle type, high when no cycle follows, held while data enable is on
assign dir_want = nxt_cyc ? wr_d : 1'b1;

always @*
begin
	if (data_enable)
		dir_d = data_direction;
	else
		dir_d = dir_want;
end

// data enable only in command states with direction already settled
always @*
begin
	den_d = 1'b0;
	if (nxt_cmd & ~start & (data_direction == dir_want))
	begin
		if (bus_timing_select & wr_d)
			den_d = go_d;
		else
			den_d = 1'b1;
	end
end

// address latch during the status state
always @*
begin
	ale_d = start;
end

// cascade strobe only for interrupt acknowledge
always @*
begin
	mce_d = start & dec[`BCCD_CMD_INT_ACK_CMD];
end

// bus state register
always @(posedge clk_sys)
begin
	if (rst)
	begin
		state_q <= `BCCD_ST_IDLE;
	end
	else
	begin
		state_q <= state_d;
	end
end

// cycle type and command enable registers
always @(posedge clk_sys)
begin
	if (rst)
	begin
		sel_q <= {`BCCD_NCMD{1'b0}};
		wr_q <= 1'b0;
		go_q <= 1'b0;
	end
	else
	begin
		sel_q <= sel_d;
		wr_q <= wr_d;
		go_q <= go_d;
	end
end

// command strobes, inactive high in reset
always @(posedge clk_sys)
begin
	if (rst)
	begin
		int_ack_cmd_n <= `BCCD_RST_CMDN;
		io_read_cmd_n <= `BCCD_RST_CMDN;
		io_write_cmd_n <= `BCCD_RST_CMDN;
		mem_read_cmd_n <= `BCCD_RST_CMDN;
		mem_write_cmd_n <= `BCCD_RST_CMDN;
	end
	else
	begin
		int_ack_cmd_n <= cmd_n_d[`BCCD_CMD_INT_ACK_CMD];
		io_read_cmd_n <= cmd_n_d[`BCCD_CMD_IORD];
		io_write_cmd_n <= cmd_n_d[`BCCD_CMD_IOWR];
		mem_read_cmd_n <= cmd_n_d[`BCCD_CMD_MRD];
		mem_write_cmd_n <= cmd_n_d[`BCCD_CMD_MWR];
	end
end

// data direction register
always @(posedge clk_sys)
begin
	if (rst)
	begin
		data_direction <= `BCCD_RST_DIR;
	end
	else
	begin
		data_direction <= dir_d;
	end
end

// data enable register
always @(posedge clk_sys)
begin
	if (rst)
	begin
		data_enable <= `BCCD_RST_DEN;
	end
	else
	begin
		data_enable <= den_d;
	end
end

// address latch register
always @(posedge clk_sys)
begin
	if (rst)
	begin
		addr_latch_strobe <= `BCCD_RST_ALE;
	end
	else
	begin
		addr_latch_strobe <= ale_d;
	end
end

// cascade register
always @(posedge clk_sys)
begin
	if (rst)
	begin
		cascade_strobe <= `BCCD_RST_MCE;
	end
	else
	begin
		cascade_strobe <= mce_d;
	end
end

endmodule

// ---- include/bccd_map.vh ----
// constants for the bus cycle command decoder
`ifndef BCCD_MAP_VH
`define BCCD_MAP_VH
// one-hot bus states
`define BCCD_ST_IDLE 4'h1
`define BCCD_ST_STAT 4'h2
`define BCCD_ST_CMD1 4'h4
`define BCCD_ST_CMD2 4'h8
// state bit positions
`define BCCD_B_IDLE 0
`define BCCD_B_STAT 1
`define BCCD_B_CMD1 2
`define BCCD_B_CMD2 3
// status codes {mem_io_select, status_hi_n, status_lo_n}
`define BCCD_CODE_INT_ACK_CMD 3'h0
`define BCCD_CODE_IORD 3'h1
`define BCCD_CODE_IOWR 3'h2
`define BCCD_CODE_HALT 3'h4
`define BCCD_CODE_MRD 3'h5
`define BCCD_CODE_MWR 3'h6
// command strobe index
`define BCCD_CMD_INT_ACK_CMD 0
`define BCCD_CMD_IORD 1
`define BCCD_CMD_IOWR 2
`define BCCD_CMD_MRD 3
`define BCCD_CMD_MWR 4
`define BCCD_NCMD 5
// reset values
`define BCCD_RST_CMD 5'h1f
`define BCCD_RST_DIR 1'h1
`define BCCD_RST_CMDN 1'h1
`define BCCD_RST_DEN 1'h0
`define BCCD_RST_ALE 1'h0
`define BCCD_RST_MCE 1'h0
`endif

// ---- tb/bccd_decoder_sva.sv ----
// assertion checker for the bus cycle command decoder
module bccd_decoder_sva (
	// clock, reset and inputs
	input wire clk_sys,
	input wire rst,
	input wire status_hi_n,
	input wire status_lo_n,
	input wire ready_n,
	// outputs
	input wire int_ack_cmd_n,
	input wire io_read_cmd_n,
	input wire io_write_cmd_n,
	input wire mem_read_cmd_n,
	input wire mem_write_cmd_n,
	input wire data_direction,
	input wire data_enable,
	input wire addr_latch_strobe,
	input wire cascade_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [4:0] cmd_n = {int_ack_cmd_n, io_read_cmd_n, io_write_cmd_n, mem_read_cmd_n, mem_write_cmd_n};
	wire rd_on = ~&{int_ack_cmd_n, io_read_cmd_n, mem_read_cmd_n};
	wire wr_on = ~&{io_write_cmd_n, mem_write_cmd_n};
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_TURN: assert property ($changed(data_direction) |-> !data_enable && !$past(data_enable)) else $error("turn");
	AST_ALE: assert property (addr_latch_strobe |=> !addr_latch_strobe) else $error("ale");
	AST_CAS: assert property (cascade_strobe |-> addr_latch_strobe ##1 !data_direction) else $error("cas");
	AST_RD: assert property (rd_on |-> !data_direction) else $error("rd dir");
	AST_WR: assert property (wr_on |-> data_direction && !rd_on) else $error("wr dir");
	AST_ONE: assert property ($onehot0(~cmd_n)) else $error("two cmds");
	AST_GO: assert property (addr_latch_strobe |-> !($past(status_hi_n) && $past(status_lo_n))) else $error("go");
	AST_WAIT: assert property ((rd_on || wr_on) && ready_n |=> rd_on || wr_on) else $error("wait");
endmodule
bind bccd_decoder bccd_decoder_sva u_sva (.*);

// ---- tb/bccd_master.sv ----
// local bus master model driving the status lines
module bccd_master (
	// clock
	input wire clk_sys,
	// status
	output logic mem_io_select,
	output logic status_hi_n,
	output logic status_lo_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {mem_io_select, status_hi_n, status_lo_n} = 3'h7;
	// status for one clock, then idle
	task cycle(input logic [2:0] code);
		{mem_io_select, status_hi_n, status_lo_n} <= code;
		@(posedge clk_sys);
		{mem_io_select, status_hi_n, status_lo_n} <= 3'h7;
	endtask
endmodule

// ---- tb/tb_bccd_decoder.sv ----
// testbench for the bus cycle command decoder
module tb_bccd_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, rst = 1, ready_n = 0, command_hold_off = 0, bus_timing_select = 0;
	wire mem_io_select, status_hi_n, status_lo_n, data_direction, data_enable, addr_latch_strobe, cascade_strobe;
	wire int_ack_cmd_n, io_read_cmd_n, io_write_cmd_n, mem_read_cmd_n, mem_write_cmd_n;
	wire [8:0] o = {int_ack_cmd_n, io_read_cmd_n, io_write_cmd_n, mem_read_cmd_n, mem_write_cmd_n,
		data_direction, data_enable, addr_latch_strobe, cascade_strobe};
	logic [5:0] tbl [8] = '{6'h1e, 6'h2e, 6'h37, 6'h3f, 6'h3f, 6'h3a, 6'h3d, 6'h3f};
	int miscompares = 0, checks = 0;
	always #50 clk_sys = ~clk_sys;
	bccd_master m (
		.clk_sys(clk_sys),
		.mem_io_select(mem_io_select),
		.status_hi_n(status_hi_n),
		.status_lo_n(status_lo_n)
	);
	bccd_decoder DUT (
		.clk_sys(clk_sys),
		.rst(rst),
		.mem_io_select(mem_io_select),
		.status_hi_n(status_hi_n),
		.status_lo_n(status_lo_n),
		.ready_n(ready_n),
		.command_hold_off(command_hold_off),
		.bus_timing_select(bus_timing_select),
		.int_ack_cmd_n(int_ack_cmd_n),
		.io_read_cmd_n(io_read_cmd_n),
		.io_write_cmd_n(io_write_cmd_n),
		.mem_read_cmd_n(mem_read_cmd_n),
		.mem_write_cmd_n(mem_write_cmd_n),
		.data_direction(data_direction),
		.data_enable(data_enable),
		.addr_latch_strobe(addr_latch_strobe),
		.cascade_strobe(cascade_strobe)
	);
	task ed(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task chk(input logic [8:0] exp);
		#1;
		checks++;
		if (o !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t out %h exp %h", $time, o, exp);
		end
	endtask
	task close_out;
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// every status code, fast timing
	task t_decode;
		logic a;
		for (int c = 0; c < 8; c++)
		begin
			a = tbl[c][5:1] != 5'h1f;
			ed(1);
			m.cycle(c[2:0]);
			chk({5'h1f, tbl[c][0], 1'b0, a, c == 0});
			ed(1);
			chk({tbl[c], a, 2'b0});
			ed(3);
			chk(9'h1f8);
		end
	endtask
	// held-off delayed write with wait states
	task t_wait;
		ed(1);
		ready_n <= 1;
		command_hold_off <= 1;
		bus_timing_select <= 1;
		m.cycle(3'h6);
		chk(9'h1fa);
		repeat (4)
		begin
			ed(1);
			chk(9'h1f8);
		end
		ed(1);
		command_hold_off <= 0;
		chk(9'h1f8);
		ed(1);
		chk(9'h1ec);
		ed(3);
		chk(9'h1ec);
		ed(1);
		ready_n <= 0;
		bus_timing_select <= 0;
		ed(3);
		chk(9'h1f8);
	endtask
	// write then interrupt acknowledge back to back
	task t_back;
		ed(1);
		m.cycle(3'h6);
		chk(9'h1fa);
		ed(1);
		chk(9'h1ec);
		ed(1);
		m.cycle(3'h0);
		chk(9'h1fb);
		ed(1);
		chk(9'h0f0);
		ed(1);
		chk(9'h0f4);
		ed(1);
		chk(9'h1f0);
		ed(1);
		chk(9'h1f8);
	endtask
	// delayed timing read with one wait state
	task t_slow;
		ed(1);
		bus_timing_select <= 1;
		m.cycle(3'h5);
		chk(9'h1f2);
		ed(1);
		chk(9'h1f4);
		ed(1);
		ready_n <= 1;
		chk(9'h1d4);
		ed(1);
		ready_n <= 0;
		chk(9'h1d4);
		ed(2);
		bus_timing_select <= 0;
		chk(9'h1f0);
		ed(1);
		chk(9'h1f8);
	endtask
	// reset in the middle of a read, then an io read
	task t_reset;
		ed(1);
		m.cycle(3'h5);
		ed(1);
		rst <= 1;
		chk(9'h1d4);
		ed(1);
		chk(9'h1f8);
		ed(1);
		rst <= 0;
		chk(9'h1f8);
		ed(1);
		m.cycle(3'h1);
		chk(9'h1f2);
		ed(1);
		chk(9'h174);
		ed(3);
		chk(9'h1f8);
	endtask
	initial
	begin
		ed(2);
		rst <= 0;
		chk(9'h1f8);
		t_decode;
		t_wait;
		t_back;
		t_slow;
		t_reset;
		close_out;
	end
	initial
	begin
		#100000;
		miscompares++;
		close_out;
	end
endmodule
